/* File: hdl/pce_pkg.sv */
package pce_pkg;
    // management register addresses
    localparam logic [4:0]  ADDR_RX_ERR   = 5'h15;
    localparam logic [4:0]  ADDR_PCS_CFG  = 5'h16;
    // coding sublayer field positions
    localparam int          BIT_QUIET     = 10;
    localparam int          BIT_FORCE_SD  = 9;
    localparam int          BIT_POLICY    = 8;
    localparam int          BIT_DESC_LONG = 7;
    localparam int          BIT_FORCE_OK  = 5;
    localparam int          BIT_NRZI_BYP  = 2;
    // tally field
    localparam int          TALLY_W       = 8;
    localparam logic [7:0]  TALLY_MAX     = 8'hff;
    localparam logic [7:0]  TALLY_ZERO    = 8'h00;
    localparam logic [7:0]  TALLY_ONE     = 8'h01;
    localparam logic [15:0] DATA_ZERO     = 16'h0000;
    // descrambler timeout figures
    localparam int          CLK_PERIOD_NS = 40;
    localparam int          DESC_LONG_US  = 2000;
    localparam int          DESC_SHORT_US = 722;
    localparam int          NS_PER_US     = 1000;
    localparam logic [15:0] TIMER_ZERO    = 16'h0000;
    localparam logic [15:0] TIMER_ONE     = 16'h0001;

    // coding sublayer control fields
    typedef struct packed {
        logic quiet_transmit_enable;
        logic force_signal_present;
        logic link_hold_policy;
        logic descrambler_timeout_select;
        logic force_good_link;
        logic nrzi_bypass;
    } pce_cfg_t;

    // reset image: hold policy set, all else cleared
    localparam pce_cfg_t    CFG_RESET     = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

    // receive side event inputs
    typedef struct packed {
        logic carrier;
        logic sym_invalid;
        logic collision;
    } pce_rx_evt_t;

    // link state
    typedef enum logic {LINK_DOWN, LINK_UP} pce_link_t;
endpackage

/* File: hdl/pce_regs.sv */
// Summary of operation
// - error register upper byte reads zero, ignores writes
// - count invalid symbol while carrier present
// - at most one count per carrier event
// - no count once a collision is seen in the event
// - tally saturates at all ones, clears on read
// - bit 10 selects true quiet transmit
// - bit 9 forces signal detect present
// - link needs valid signal and descrambler lock
// - hold policy set: ignore descrambler lock loss
// - hold policy clear: link needs lock too
// - descrambler timeout 2ms or 722us by bit 7
// - bit 5 forces good 100 link
// - bit 2 bypasses line encoding
`timescale 1ns/1ps
module pce_regs #(
    parameter logic [15:0] DESC_LONG_CYC  =
        16'(pce_pkg::DESC_LONG_US * pce_pkg::NS_PER_US / pce_pkg::CLK_PERIOD_NS),
    parameter logic [15:0] DESC_SHORT_CYC =
        16'(pce_pkg::DESC_SHORT_US * pce_pkg::NS_PER_US / pce_pkg::CLK_PERIOD_NS)
) (
    input  wire logic                 REF_CLK,
    input  wire logic                 RST_B,
    input  wire logic [4:0]           MGMT_ADDR,
    input  wire logic                 MGMT_WR,
    input  wire logic                 MGMT_RD,
    input  wire logic [15:0]          MGMT_WDATA,
    output logic      [15:0]          MGMT_RDATA,
    input  wire pce_pkg::pce_rx_evt_t RX_EVT,
    input  wire logic                 SIGNAL_LEVEL_OK,
    input  wire logic                 DESCR_SYNC,
    output logic                      TX_QUIET,
    output logic                      SIGNAL_PRESENT,
    output logic                      DESCR_LOCKED,
    output logic                      LINK_100_OK,
    output logic                      NRZI_BYPASS_EN
);
    pce_pkg::pce_cfg_t  cfg_ff;         // coding sublayer control
    logic [7:0]         tally_ff;       // receive symbol fault tally
    logic               counted_ff;     // event already counted
    logic               coll_seen_ff;   // collision seen in event
    logic [15:0]        timer_ff;       // descrambler idle timer
    logic               lock_ff;        // descrambler lock state
    pce_pkg::pce_link_t link_ff;        // link state
    logic [15:0]        rdata_ff;       // read data holding
    logic               quiet_ff;       // registered quiet output
    logic               sigp_ff;        // registered signal present
    logic               nrzi_ff;        // registered bypass output

    logic               rd_tally;       // read of tally register
    logic               inc_tally;      // count this cycle
    logic               sd_eff;         // effective signal detect
    logic [15:0]        timeout_lim;    // selected timeout count
    logic [15:0]        pcs_image;      // coding sublayer read image
    logic [15:0]        nxt_rdata;      // next read data

    assign rd_tally = MGMT_RD && (MGMT_ADDR == pce_pkg::ADDR_RX_ERR);

    // one count per event, none if collision seen
    // single count gate
    assign inc_tally = RX_EVT.carrier && RX_EVT.sym_invalid && !RX_EVT.collision
                       && !coll_seen_ff && !counted_ff;

    assign sd_eff = SIGNAL_LEVEL_OK || cfg_ff.force_signal_present;

    assign timeout_lim = cfg_ff.descrambler_timeout_select ? DESC_LONG_CYC : DESC_SHORT_CYC;

    // read image of coding sublayer register, reserved bits zero
    always_comb begin
        pcs_image = pce_pkg::DATA_ZERO;
        pcs_image[pce_pkg::BIT_QUIET]     = cfg_ff.quiet_transmit_enable;
        pcs_image[pce_pkg::BIT_FORCE_SD]  = cfg_ff.force_signal_present;
        pcs_image[pce_pkg::BIT_POLICY]    = cfg_ff.link_hold_policy;
        pcs_image[pce_pkg::BIT_DESC_LONG] = cfg_ff.descrambler_timeout_select;
        pcs_image[pce_pkg::BIT_FORCE_OK]  = cfg_ff.force_good_link;
        pcs_image[pce_pkg::BIT_NRZI_BYP]  = cfg_ff.nrzi_bypass;
    end

    // read data mux, unmapped reads zero
    always_comb begin
        nxt_rdata = rdata_ff;
        if (MGMT_RD) begin
            case (MGMT_ADDR)
                pce_pkg::ADDR_RX_ERR:  nxt_rdata = {pce_pkg::TALLY_ZERO, tally_ff};
                pce_pkg::ADDR_PCS_CFG: nxt_rdata = pcs_image;
                default:               nxt_rdata = pce_pkg::DATA_ZERO;
            endcase
        end
    end

    // read data register
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_ff <= pce_pkg::DATA_ZERO;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // control register write, reserved bits dropped
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_ff <= pce_pkg::CFG_RESET;
        end else if (MGMT_WR && (MGMT_ADDR == pce_pkg::ADDR_PCS_CFG)) begin
            cfg_ff.quiet_transmit_enable      <= MGMT_WDATA[pce_pkg::BIT_QUIET];
            cfg_ff.force_signal_present       <= MGMT_WDATA[pce_pkg::BIT_FORCE_SD];
            cfg_ff.link_hold_policy           <= MGMT_WDATA[pce_pkg::BIT_POLICY];
            cfg_ff.descrambler_timeout_select <= MGMT_WDATA[pce_pkg::BIT_DESC_LONG];
            cfg_ff.force_good_link            <= MGMT_WDATA[pce_pkg::BIT_FORCE_OK];
            cfg_ff.nrzi_bypass                <= MGMT_WDATA[pce_pkg::BIT_NRZI_BYP];
        end
    end

    // fault tally, count beats clear in same cycle
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            tally_ff <= pce_pkg::TALLY_ZERO;
        end else if (rd_tally) begin
            tally_ff <= inc_tally ? pce_pkg::TALLY_ONE : pce_pkg::TALLY_ZERO;
        end else if (inc_tally && (tally_ff != pce_pkg::TALLY_MAX)) begin
            tally_ff <= tally_ff + pce_pkg::TALLY_ONE;
        end
    end

    // per carrier event tracking
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            counted_ff   <= 1'b0;
            coll_seen_ff <= 1'b0;
        end else if (!RX_EVT.carrier) begin
            // event over, rearm
            counted_ff   <= 1'b0;
            coll_seen_ff <= 1'b0;
        end else begin
            if (inc_tally) begin
                counted_ff <= 1'b1;
            end
            if (RX_EVT.collision) begin
                coll_seen_ff <= 1'b1;
            end
        end
    end

    // descrambler lock timer: sync restarts, timeout drops lock
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            timer_ff <= pce_pkg::TIMER_ZERO;
            lock_ff  <= 1'b0;
        end else if (DESCR_SYNC) begin
            timer_ff <= pce_pkg::TIMER_ZERO;
            lock_ff  <= 1'b1;
        end else if (lock_ff) begin
            if (timer_ff >= timeout_lim - pce_pkg::TIMER_ONE) begin
                lock_ff  <= 1'b0;
                timer_ff <= pce_pkg::TIMER_ZERO;
            end else begin
                timer_ff <= timer_ff + pce_pkg::TIMER_ONE;
            end
        end
    end

    // link state machine
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            link_ff <= pce_pkg::LINK_DOWN;
        end else begin
            case (link_ff)
                pce_pkg::LINK_DOWN: begin
                    if (sd_eff && lock_ff) begin
                        link_ff <= pce_pkg::LINK_UP;
                    end
                end
                pce_pkg::LINK_UP: begin
                    if (!sd_eff || (!cfg_ff.link_hold_policy && !lock_ff)) begin
                        link_ff <= pce_pkg::LINK_DOWN;
                    end
                end
                default: link_ff <= pce_pkg::LINK_DOWN;
            endcase
        end
    end

    // registered control outputs
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            quiet_ff <= 1'b0;
            sigp_ff  <= 1'b0;
            nrzi_ff  <= 1'b0;
        end else begin
            quiet_ff <= cfg_ff.quiet_transmit_enable;
            sigp_ff  <= sd_eff;
            nrzi_ff  <= cfg_ff.nrzi_bypass;
        end
    end

    // good link output, forced or from state
    logic link_out_ff;  // registered link indication
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            link_out_ff <= 1'b0;
        end else begin
            link_out_ff <= cfg_ff.force_good_link || (link_ff == pce_pkg::LINK_UP);
        end
    end

    assign MGMT_RDATA     = rdata_ff;
    assign TX_QUIET       = quiet_ff;
    assign SIGNAL_PRESENT = sigp_ff;
    assign DESCR_LOCKED   = lock_ff;
    assign LINK_100_OK    = link_out_ff;
    assign NRZI_BYPASS_EN = nrzi_ff;

    // checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    upper_byte_zero_a: assert property (
        $past(rd_tally) |-> MGMT_RDATA[15:8] == pce_pkg::TALLY_ZERO)
        else $error("tally upper byte not zero");
    tally_inc_a: assert property (
        inc_tally && !rd_tally && tally_ff != pce_pkg::TALLY_MAX
        |=> tally_ff == $past(tally_ff) + pce_pkg::TALLY_ONE)
        else $error("tally did not count");
    one_per_event_a: assert property (
        counted_ff && RX_EVT.carrier && !rd_tally |=> tally_ff == $past(tally_ff))
        else $error("tally counted twice in one event");
    coll_block_a: assert property (
        RX_EVT.collision && !rd_tally |=> tally_ff == $past(tally_ff))
        else $error("tally counted under collision");
    tally_sat_a: assert property (
        tally_ff == pce_pkg::TALLY_MAX && !rd_tally |=> tally_ff == pce_pkg::TALLY_MAX)
        else $error("tally wrapped");
    tally_clr_a: assert property (
        rd_tally && !inc_tally |=> tally_ff == pce_pkg::TALLY_ZERO)
        else $error("tally not cleared by read");
    quiet_follow_a: assert property (
        MGMT_WR && MGMT_ADDR == pce_pkg::ADDR_PCS_CFG
        |-> ##2 TX_QUIET == $past(MGMT_WDATA[pce_pkg::BIT_QUIET], 2))
        else $error("quiet output wrong");
    force_sd_a: assert property (
        cfg_ff.force_signal_present |=> SIGNAL_PRESENT)
        else $error("signal detect not forced");
    link_needs_lock_a: assert property (
        link_ff == pce_pkg::LINK_DOWN && !(sd_eff && lock_ff)
        |=> link_ff == pce_pkg::LINK_DOWN)
        else $error("link rose without signal and lock");
    hold_policy_a: assert property (
        link_ff == pce_pkg::LINK_UP && sd_eff && cfg_ff.link_hold_policy
        |=> link_ff == pce_pkg::LINK_UP)
        else $error("link dropped under hold policy");
    strict_policy_a: assert property (
        link_ff == pce_pkg::LINK_UP && !cfg_ff.link_hold_policy && !lock_ff
        |=> link_ff == pce_pkg::LINK_DOWN)
        else $error("link kept without lock");
    timeout_len_a: assert property (
        lock_ff && !DESCR_SYNC && timer_ff == timeout_lim - pce_pkg::TIMER_ONE
        |=> !lock_ff)
        else $error("descrambler timeout wrong");
    force_ok_a: assert property (
        cfg_ff.force_good_link |=> LINK_100_OK)
        else $error("good link not forced");
    nrzi_follow_a: assert property (
        ##1 NRZI_BYPASS_EN == $past(cfg_ff.nrzi_bypass))
        else $error("bypass output wrong");
    tally_wr_ign_a: assert property (
        MGMT_WR && MGMT_ADDR == pce_pkg::ADDR_RX_ERR && !inc_tally && !rd_tally
        |=> tally_ff == $past(tally_ff))
        else $error("tally took a write");
    sd_follow_a: assert property (
        ##1 SIGNAL_PRESENT == ($past(SIGNAL_LEVEL_OK) || $past(cfg_ff.force_signal_present)))
        else $error("signal present wrong");
    link_rise_a: assert property (
        link_ff == pce_pkg::LINK_DOWN && sd_eff && lock_ff |=> link_ff == pce_pkg::LINK_UP)
        else $error("link stayed down with signal and lock");
    sync_lock_a: assert property (
        DESCR_SYNC |=> lock_ff && timer_ff == pce_pkg::TIMER_ZERO)
        else $error("sync did not restore lock");

    sat_cover_c:   cover property (tally_ff == pce_pkg::TALLY_MAX);
    link_up_c:     cover property (link_ff == pce_pkg::LINK_DOWN ##1 link_ff == pce_pkg::LINK_UP);
    lock_loss_c:   cover property (lock_ff ##1 !lock_ff);
    rd_and_inc_c:  cover property (rd_tally && inc_tally);
    coll_evt_c:    cover property (RX_EVT.carrier && RX_EVT.collision && RX_EVT.sym_invalid);
endmodule

/* File: test/pce_host_model.sv */
`timescale 1ns/1ps
// management host: one strobe request at a time on the register port
module pce_host_model (
    input  wire logic        clk,
    output logic      [4:0]  addr,
    output logic             wr,
    output logic             rd,
    output logic      [15:0] wdata,
    input  wire logic [15:0] rdata
);
    int idle_gap = 0; // extra idle edges before a request (slow host)
    initial begin
        addr  = 5'h00;
        wr    = 1'b0;
        rd    = 1'b0;
        wdata = 16'h0000;
    end
    // one write pulse; raw keeps reserved bits for fault scenarios
    task automatic put(input logic [4:0] a, input logic [15:0] d, input bit raw);
        repeat (idle_gap) @(posedge clk);
        @(posedge clk);
        addr  <= a;
        wdata <= (raw || a != pce_pkg::ADDR_PCS_CFG) ? d : d & 16'h07a4;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        // released bus shows the inverse, not the last value
        addr  <= ~a;
        wdata <= ~d;
    endtask
    // one read pulse; data taken once it has settled
    task automatic get(input logic [4:0] a, output logic [15:0] d);
        repeat (idle_gap) @(posedge clk);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
        @(negedge clk);
        d = rdata;
    endtask
endmodule

/* File: test/pcs_config_rx_error_counter_bench.sv */
`timescale 1ns/1ps
module pcs_config_rx_error_counter_bench;
    localparam int        LONG_C  = 20; // shortened long timeout
    localparam int        SHORT_C = 8;  // shortened short timeout
    logic                 ref_clk = 1'b0;
    logic                 rst_b   = 1'b0;
    pce_pkg::pce_rx_evt_t rx_evt  = '0;
    logic                 lvl_ok  = 1'b0;
    logic                 sync    = 1'b0;
    logic [4:0]           addr;
    logic                 wr, rd;
    logic [15:0]          wdata, rdata, got, d;
    logic                 quiet, present, locked, link_ok, nrzi;
    int                   errors  = 0;
    int                   n_tests = 0;
    logic [31:0]          seed    = 32'haed6;
    logic [7:0]           exp_tally = 8'h00; // tally the bench expects
    int                   bits[6] = '{pce_pkg::BIT_QUIET, pce_pkg::BIT_FORCE_SD,
        pce_pkg::BIT_POLICY, pce_pkg::BIT_DESC_LONG, pce_pkg::BIT_FORCE_OK,
        pce_pkg::BIT_NRZI_BYP};
    // free running clock
    always #20 ref_clk = ~ref_clk;
    pce_host_model host_u (.clk(ref_clk), .addr(addr), .wr(wr), .rd(rd),
        .wdata(wdata), .rdata(rdata));
    pce_regs #(.DESC_LONG_CYC(16'(LONG_C)), .DESC_SHORT_CYC(16'(SHORT_C))) dut_u (
        .REF_CLK(ref_clk), .RST_B(rst_b), .MGMT_ADDR(addr), .MGMT_WR(wr),
        .MGMT_RD(rd), .MGMT_WDATA(wdata), .MGMT_RDATA(rdata), .RX_EVT(rx_evt),
        .SIGNAL_LEVEL_OK(lvl_ok), .DESCR_SYNC(sync), .TX_QUIET(quiet),
        .SIGNAL_PRESENT(present), .DESCR_LOCKED(locked), .LINK_100_OK(link_ok),
        .NRZI_BYPASS_EN(nrzi));
    // xorshift step
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // saturating expected tally
    function automatic logic [7:0] tally_next(input logic [7:0] t, input logic hit);
        return (hit && t != 8'hff) ? t + 8'h01 : t;
    endfunction
    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: word %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: flag %b expected %b", $time, g, e);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    // one carrier event, then carrier low to end it
    task automatic send_evt(input int len, input logic [7:0] inv, input logic coll);
        for (int i = 0; i < len; i++) begin
            @(posedge ref_clk);
            rx_evt <= {1'b1, inv[i], coll};
        end
        @(posedge ref_clk);
        rx_evt <= '0;
        @(posedge ref_clk);
        exp_tally = tally_next(exp_tally, !coll && |(inv & 8'((1 << len) - 1)));
    endtask
    // read the error register, which also clears the tally
    task automatic check_tally;
        host_u.get(pce_pkg::ADDR_RX_ERR, got);
        chk_word(got, {8'h00, exp_tally});
        exp_tally = 8'h00;
    endtask
    task automatic pulse_sync;
        @(posedge ref_clk);
        sync <= 1'b1;
        @(posedge ref_clk);
        sync <= 1'b0;
    endtask
    // lock must still stand shortly before the limit and be gone just after
    task automatic lock_window(input int lim);
        pulse_sync;
        settle(lim - 3);
        chk_bit(locked, 1'b1);
        settle(5);
        chk_bit(locked, 1'b0);
    endtask
    // watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        finish_test;
    end
    // main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        host_u.get(pce_pkg::ADDR_PCS_CFG, got);
        chk_word(got, 16'h0100);
        check_tally;
        // each field alone, then random words, with prompt and slow host
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            d = (i < 6) ? 16'h0001 << bits[i] : seed[15:0] & 16'h07a4;
            host_u.idle_gap = i % 3;
            host_u.put(pce_pkg::ADDR_PCS_CFG, d, 1'b0);
            host_u.get(pce_pkg::ADDR_PCS_CFG, got);
            chk_word(got, d);
            settle(1);
            chk_bit(quiet, d[10]);
            chk_bit(present, d[9]);
            chk_bit(link_ok, d[5]);
            chk_bit(nrzi, d[2]);
        end
        host_u.idle_gap = 0;
        // reserved coding bits dropped on a careless write
        host_u.put(pce_pkg::ADDR_PCS_CFG, 16'hffff, 1'b1);
        host_u.get(pce_pkg::ADDR_PCS_CFG, got);
        chk_word(got, 16'h07a4);
        send_evt(4, 8'h0f, 1'b0);
        send_evt(3, 8'h07, 1'b1);
        host_u.put(pce_pkg::ADDR_RX_ERR, 16'hffff, 1'b1);
        check_tally;
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            send_evt(1 + int'(seed[1:0]), seed[15:8], seed[5:4] == 2'b00);
            if (i % 6 == 5)
                check_tally;
        end
        for (int i = 0; i < 260; i++)
            send_evt(1, 8'h01, 1'b0);
        check_tally;
        check_tally;
        @(posedge ref_clk);
        lvl_ok <= 1'b1;
        host_u.put(pce_pkg::ADDR_PCS_CFG, 16'h0100, 1'b0);
        settle(2);
        chk_bit(link_ok, 1'b0);
        chk_bit(present, 1'b1);
        pulse_sync;
        settle(3);
        chk_bit(link_ok, 1'b1);
        settle(LONG_C + 4);
        chk_bit(locked, 1'b0);
        chk_bit(link_ok, 1'b1);
        host_u.put(pce_pkg::ADDR_PCS_CFG, 16'h0000, 1'b0);
        settle(3);
        chk_bit(link_ok, 1'b0);
        lock_window(SHORT_C);
        host_u.put(pce_pkg::ADDR_PCS_CFG, 16'h0080, 1'b0);
        lock_window(LONG_C);
        finish_test;
    end
endmodule
